// *** hw/gauge_control_subcommand_unit.v ***
// Control subcommand interpreter of the fuel gauge
// What this block does
// - Locked state allows only read-only query subcommands
// - Status subcommand returns the control-status word
// - High byte holds lock, calibration, checksum flags
// - Low byte holds sleep, power, update flags
// - Calibration and deep sleep flags reset to zero; power-mode flag follows its input
// - Type, firmware, hardware version queries answer
// - Reset count query, unlocked only
// - Last subcommand query, value kept below limit
// - Chemistry code and flash version queries
// - Board calibration runs with its flag set
// - Counter calibration with flag; store saves offset
// - Deep sleep arm sets deep sleep flag
// - Deep sleep wake stretches first message on two-wire link, drops it on single-wire
// - Traffic in deep sleep returns to sleep
// - Chemistry sum is fifteen bit masked sum
// - Sum top bit marks reference mismatch
// - Current query allowed in both states
// - Lock subcommand enters locked access state
// - Algorithm start sets update bit and flags
// - Voltage flag follows; capacity enable stays set
// - Calibration toggle; offset query in calibration
// - Full reset subcommand refused when locked
// - Enter and exit calibration drive the flag
// - Each access is two serial transfers
`timescale 1ns/1ns
`default_nettype none
`include "gauge_ctl_consts.vh"
module gauge_control_subcommand_unit #(
    parameter [15:0] TYPE_CODE  = 16'h1234, // Arbitrary identity value
    parameter [15:0] FW_REV     = 16'h0101, // Arbitrary firmware revision
    parameter [15:0] HW_REV     = 16'h0001, // Arbitrary hardware revision
    parameter [15:0] CHEM_CODE  = 16'h0100, // Plain default chemistry code
    parameter [15:0] FLASH_REV  = 16'h0001, // Plain default flash version
    parameter [31:0] WAKE_COUNT = `WAKE_CYCLES
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        wr_i,          // Host byte write strobe
    input  wire        rd_i,          // Host byte read strobe
    input  wire [7:0]  addr_i,        // Command code address
    input  wire [7:0]  wdata_i,       // Host write byte
    output reg  [7:0]  rdata_o,       // Host read byte
    output wire        stretch_o,     // Hold the link clock low
    output wire        drop_o,        // Single-wire message discarded
    input  wire        link_sel_i,    // 1 = single-wire link in use
    input  wire        sleep_i,       // Device is in sleep state
    input  wire        volt_ok_i,     // Voltages suit capacity update
    input  wire        res_upd_dis_i, // Resistance updates disabled
    input  wire        power_mode_i,  // Constant-power mode selected
    input  wire [15:0] current_i,     // Latest instantaneous current
    input  wire [15:0] offset_i,      // Measured counter offset
    input  wire [15:0] chem_word_i,   // Chemistry table word
    input  wire [15:0] chem_ref_i,    // Stored chemistry reference
    input  wire        cal_done_i,    // Calibration measurement finished
    output wire [`CHEM_IDX_W-1:0] chem_idx_o,
    output reg         board_cal_o,   // Board calibration running
    output reg         cnt_cal_o,     // Counter calibration running
    output reg         offset_store_o,// Pulse: save counter offset
    output reg         full_reset_o,  // Pulse: whole-device reset
    output reg         deep_sleep_o,  // Deep sleep power mode active
    output reg  [7:0]  update_state_o // Update state value
);
    reg [7:0]  sub_lo_q;       // Low subcommand byte pending
    reg [15:0] result_q;       // Word returned at the control addresses
    reg [15:0] last_sub_q;     // Previously written subcommand
    reg [15:0] reset_cnt_q;    // Number of resets performed
    reg        locked_q;       // Locked access state
    reg        full_lock_q;    // Full-access locked state
    reg        cal_active_q;   // Calibration mode
    reg        sum_valid_q;    // Checksum generated
    reg        deep_arm_q;     // Deep sleep armed
    reg        cap_en_q;       // Capacity update enable, sticky
    reg        alg_on_q;       // Algorithm running
    reg        sum_pend_q;     // Chemistry sum result awaited
    reg        waking_q;       // Oscillator restart under way
    reg [31:0] wake_cnt_q;     // Restart countdown
    reg        dropped_q;      // First single-wire message already dropped
    wire [15:0] status_word;   // Assembled status word
    wire [15:0] sub_word;      // Complete subcommand on high byte write
    wire        sub_wr;        // High byte write completes subcommand
    wire        any_access;    // Any host traffic
    wire        allowed;       // Subcommand permitted now
    wire        sum_busy;
    wire        sum_done;
    wire [15:0] sum_result;
    reg         sum_start;
    reg         is_query;      // Locked-state permitted subcommands

    // Status word assembly; unused bits read zero
    assign status_word = {1'b0, full_lock_q, locked_q, cal_active_q,
                          cnt_cal_o, board_cal_o, sum_valid_q, 1'b0,
                          2'b00, deep_arm_q, sleep_i, power_mode_i,
                          res_upd_dis_i, volt_ok_i & alg_on_q, cap_en_q};

    // Low byte then high byte form the subcommand; two transfers per access
    assign sub_wr     = wr_i && (addr_i == `CTL_ADDR_HI);
    assign sub_word   = {wdata_i, sub_lo_q};
    assign any_access = wr_i || rd_i;
    assign stretch_o  = waking_q && !link_sel_i;
    assign drop_o     = waking_q && link_sel_i && !dropped_q;

    // Which subcommands survive the locked state
    always @* begin
        case (sub_word)
            `SC_STATUS, `SC_TYPE, `SC_FW_REV, `SC_HW_REV, `SC_CHEM_CODE,
            `SC_FLASH_REV, `SC_CHEM_SUM, `SC_CURRENT: is_query = 1'b1;
            default: is_query = 1'b0;
        endcase
    end

    // Anything else needs the unlocked state; refused writes change nothing
    assign allowed = !locked_q || is_query;

    // A sum starts only when an allowed checksum subcommand arrives
    always @* begin
        sum_start = sub_wr && !waking_q && !deep_sleep_o && allowed && (sub_word == `SC_CHEM_SUM);
    end

    chem_sum_unit u_sum (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .start_i  (sum_start),
        .word_i   (chem_word_i),
        .ref_i    (chem_ref_i),
        .idx_o    (chem_idx_o),
        .busy_o   (sum_busy),
        .done_o   (sum_done),
        .result_o (sum_result)
    );

    // Read data: both addresses show the result word
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && addr_i == `CTL_ADDR_LO) begin
            rdata_o <= result_q[7:0];
        end else if (rd_i && addr_i == `CTL_ADDR_HI) begin
            rdata_o <= result_q[15:8];
        end
    end

    // Reset counter survives the full-reset pulse it counts
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            reset_cnt_q <= 16'h0000;
        end else if (full_reset_o) begin
            reset_cnt_q <= reset_cnt_q + 16'h0001;
        end
    end

    // Deep sleep wake: oscillator restart window
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            waking_q   <= 1'b0;
            wake_cnt_q <= 32'h0000_0000;
            dropped_q  <= 1'b0;
        end else if (deep_sleep_o && any_access) begin
            // First message after deep sleep starts the restart
            waking_q   <= 1'b1;
            wake_cnt_q <= WAKE_COUNT;
            dropped_q  <= 1'b0;
        end else if (waking_q) begin
            if (link_sel_i && any_access) begin
                dropped_q <= 1'b1;
            end
            if (wake_cnt_q <= 32'h0000_0001) begin
                waking_q <= 1'b0;
            end else begin
                wake_cnt_q <= wake_cnt_q - 32'h0000_0001;
            end
        end
    end

    // Main interpreter
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            sub_lo_q       <= 8'h00;
            result_q       <= 16'h0000;
            last_sub_q     <= 16'h0000;
            locked_q       <= 1'b0;
            full_lock_q    <= 1'b0;
            cal_active_q   <= 1'b0;
            sum_valid_q    <= 1'b0;
            deep_arm_q     <= 1'b0;
            deep_sleep_o   <= 1'b0;
            cap_en_q       <= 1'b0;
            alg_on_q       <= 1'b0;
            sum_pend_q     <= 1'b0;
            board_cal_o    <= 1'b0;
            cnt_cal_o      <= 1'b0;
            offset_store_o <= 1'b0;
            full_reset_o   <= 1'b0;
            update_state_o <= 8'h00;
        end else begin
            offset_store_o <= 1'b0;
            full_reset_o   <= 1'b0;
            // Calibration runs end when the measurement reports done
            if (cal_done_i) begin
                board_cal_o <= 1'b0;
                cnt_cal_o   <= 1'b0;
            end
            // Deep sleep entered once armed and the sleep state is seen
            if (deep_arm_q && sleep_i && !any_access) begin
                deep_sleep_o <= 1'b1;
            end
            // Host traffic ends deep sleep and clears the flag
            if (deep_sleep_o && any_access) begin
                deep_sleep_o <= 1'b0;
                deep_arm_q   <= 1'b0;
            end
            // Checksum answer lands in the result word
            if (sum_done && sum_pend_q) begin
                result_q    <= sum_result;
                sum_valid_q <= 1'b1;
                sum_pend_q  <= 1'b0;
            end
            if (wr_i && addr_i == `CTL_ADDR_LO && !waking_q && !deep_sleep_o) begin
                sub_lo_q <= wdata_i;
            end
            // Writes during restart are not taken
            if (sub_wr && !waking_q && !deep_sleep_o && allowed) begin
                if (sub_word < `LAST_SUB_LIMIT) begin
                    last_sub_q <= sub_word;
                end
                case (sub_word)
                    `SC_STATUS:      result_q <= status_word;
                    `SC_TYPE:        result_q <= TYPE_CODE;
                    `SC_FW_REV:      result_q <= FW_REV;
                    `SC_HW_REV:      result_q <= HW_REV;
                    `SC_RESET_COUNT: result_q <= reset_cnt_q;
                    `SC_LAST_SUB:    result_q <= last_sub_q;
                    `SC_CHEM_CODE:   result_q <= CHEM_CODE;
                    `SC_FLASH_REV:   result_q <= FLASH_REV;
                    `SC_BOARD_CAL:   board_cal_o <= 1'b1;
                    `SC_CNT_CAL:     cnt_cal_o <= 1'b1;
                    `SC_CNT_STORE:   offset_store_o <= 1'b1;
                    `SC_DEEP_SLEEP:  deep_arm_q <= 1'b1;
                    `SC_CHEM_SUM:    sum_pend_q <= 1'b1;
                    `SC_CURRENT:     result_q <= current_i;
                    `SC_LOCK: begin
                        locked_q    <= 1'b1;
                        full_lock_q <= 1'b1;
                    end
                    `SC_ALG_START: begin
                        alg_on_q <= 1'b1;
                        cap_en_q <= 1'b1;
                        update_state_o[`UPD_ALG_BIT] <= 1'b1;
                    end
                    `SC_CAL_TOGGLE:  cal_active_q <= !cal_active_q;
                    `SC_CAL_OFFSET: begin
                        if (cal_active_q) begin
                            result_q <= offset_i;
                        end
                    end
                    `SC_FULL_RESET:  full_reset_o <= 1'b1;
                    `SC_CAL_EXIT:    cal_active_q <= 1'b0;
                    `SC_CAL_ENTER:   cal_active_q <= 1'b1;
                    default: begin
                        // Unknown codes below the limit only update the last subcommand
                        result_q <= result_q;
                    end
                endcase
            end
        end
    end
endmodule // gauge_control_subcommand_unit
`default_nettype wire

// *** include/gauge_ctl_consts.vh ***
// Constants for the gauge control subcommand unit
`ifndef GAUGE_CTL_CONSTS_VH
`define GAUGE_CTL_CONSTS_VH
// Command code addresses of the control word
`define CTL_ADDR_LO        8'h00
`define CTL_ADDR_HI        8'h01
// Subcommand codes
`define SC_STATUS          16'h0000
`define SC_TYPE            16'h0001
`define SC_FW_REV          16'h0002
`define SC_HW_REV          16'h0003
`define SC_RESET_COUNT     16'h0005
`define SC_LAST_SUB        16'h0007
`define SC_CHEM_CODE       16'h0008
`define SC_BOARD_CAL       16'h0009
`define SC_CNT_CAL         16'h000a
`define SC_CNT_STORE       16'h000b
`define SC_FLASH_REV       16'h000c
`define SC_DEEP_SLEEP      16'h0010
`define SC_CHEM_SUM        16'h0017
`define SC_CURRENT         16'h0018
`define SC_LOCK            16'h0020
`define SC_ALG_START       16'h0021
`define SC_CAL_TOGGLE      16'h002d
`define SC_FULL_RESET      16'h0041
`define SC_CAL_EXIT        16'h0080
`define SC_CAL_ENTER       16'h0081
`define SC_CAL_OFFSET      16'h0082
// Limit on the reported last subcommand
`define LAST_SUB_LIMIT     16'h0020
// Status word bit positions
`define ST_FULL_LOCK       14
`define ST_LOCKED          13
`define ST_CAL_ACTIVE      12
`define ST_CNT_CAL         11
`define ST_BOARD_CAL       10
`define ST_SUM_VALID       9
`define ST_DEEP_SLEEP      5
`define ST_SLEEP           4
`define ST_POWER_MODE      3
`define ST_RES_UPD_DIS     2
`define ST_VOLT_OK         1
`define ST_CAP_UPD_EN      0
// Update state bit set by algorithm start
`define UPD_ALG_BIT        2
// Wake stretch time in microseconds and its cycle count at 25 MHz
`define CLK_MHZ            25
`define WAKE_MIN_US        6000
`define WAKE_CYCLES        (`WAKE_MIN_US * `CLK_MHZ)
// Length of the static chemistry table
`define CHEM_WORDS         16
`define CHEM_IDX_W         4
`endif

// *** hw/chem_sum_unit.v ***
// Sums the static chemistry table and checks it against the stored reference
`timescale 1ns/1ns
`default_nettype none
`include "gauge_ctl_consts.vh"
module chem_sum_unit (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        start_i,
    input  wire [15:0] word_i,
    input  wire [15:0] ref_i,
    output wire [`CHEM_IDX_W-1:0] idx_o,
    output reg         busy_o,
    output reg         done_o,
    output reg  [15:0] result_o
);
    reg [15:0]             acc_q;    // Running 16-bit unsigned sum
    reg [`CHEM_IDX_W-1:0]  idx_q;    // Table index being added
    wire [15:0]            acc_next; // Sum including current word
    wire [14:0]            sum15;    // Sum with top bit masked

    assign idx_o    = idx_q;
    assign acc_next = acc_q + word_i;
    assign sum15    = acc_next[14:0];

    // One word per cycle; the table is short so the walk is cheap
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            acc_q    <= 16'h0000;
            idx_q    <= {`CHEM_IDX_W{1'b0}};
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
            result_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                // Fresh pass
                acc_q  <= 16'h0000;
                idx_q  <= {`CHEM_IDX_W{1'b0}};
                busy_o <= 1'b1;
            end else if (busy_o) begin
                acc_q <= acc_next;
                idx_q <= idx_q + 1'b1;
                if (idx_q == `CHEM_WORDS - 1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    // Top bit flags a mismatch against the reference
                    result_o <= {(sum15 != ref_i[14:0]), sum15};
                end
            end
        end
    end
endmodule // chem_sum_unit
`default_nettype wire

// *** tb/host_model.sv ***
// Host processor model that drives the control command bytes
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic        clock_i,
    input  wire logic [3:0]  idx_i,   // Chemistry table index
    input  wire logic [7:0]  rdata_i, // Read byte from the unit
    output logic             wr_o,    // Byte write strobe
    output logic             rd_o,    // Byte read strobe
    output logic [7:0]       addr_o,  // Command code address
    output logic [7:0]       wdata_o, // Write byte
    output logic [15:0]      word_o   // Chemistry word at idx_i
);
    logic [15:0] table_q [16]; // Static chemistry table, filled by the bench
    initial begin
        {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
    end
    // Table answers the index at once, like a flash array read
    assign word_o = table_q[idx_i];
    // One byte write; idle lines show inverted values so stale data never passes
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(negedge clock_i);
        {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    endtask
    // Subcommand: low byte first, then the high byte that executes
    task automatic cmd(input logic [15:0] c);
        put(8'h00, c[7:0]);
        put(8'h01, c[15:8]);
    endtask
    // One byte read; the byte is registered one cycle after the strobe
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        {rd_o, addr_o} = {1'b1, a};
        @(negedge clock_i);
        {rd_o, addr_o} = {1'b0, ~a};
        d = rdata_i;
    endtask
    // Result word read back as two transfers
    task automatic read_word(output logic [15:0] w);
        get(8'h00, w[7:0]);
        get(8'h01, w[15:8]);
    endtask
endmodule // host_model
`default_nettype wire

// *** tb/gauge_ctl_sva.sv ***
// Port-level assertions of the control subcommand unit
`timescale 1ns/1ns
`default_nettype none
`include "gauge_ctl_consts.vh"
module gauge_ctl_sva #(
    parameter [31:0] WAKE_COUNT = 32'd10
) (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       stretch_o,
    input wire logic       drop_o,
    input wire logic       link_sel_i,
    input wire logic       cal_done_i,
    input wire logic       board_cal_o,
    input wire logic       cnt_cal_o,
    input wire logic       offset_store_o,
    input wire logic       full_reset_o,
    input wire logic       deep_sleep_o,
    input wire logic [7:0] update_state_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0]  lo_q;     // Last accepted low subcommand byte
    logic        locked_q; // Locked state as seen from the bus
    logic [31:0] st_cnt_q; // Length of the running stretch
    // Writes are swallowed while asleep or waking
    wire         awake = !deep_sleep_o && !stretch_o && !drop_o;
    wire         go = wr_i && addr_i == `CTL_ADDR_HI && awake;
    wire  [15:0] code = {wdata_i, lo_q};
    // Shadow of the byte pairing and the lock state
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            {lo_q, locked_q, st_cnt_q} <= 41'h0;
        end else begin
            if (wr_i && addr_i == `CTL_ADDR_LO && awake) lo_q <= wdata_i;
            if (go && code == `SC_LOCK) locked_q <= 1'b1;
            st_cnt_q <= stretch_o ? st_cnt_q + 32'd1 : 32'd0;
        end
    end
    board_cal_start_a: assert property (go && !locked_q && code == `SC_BOARD_CAL |=> board_cal_o)
        else $error("board calibration did not start");
    cnt_cal_start_a: assert property (go && !locked_q && code == `SC_CNT_CAL |=> cnt_cal_o)
        else $error("counter calibration did not start");
    cal_done_clear_a: assert property (cal_done_i && !go |=> !board_cal_o && !cnt_cal_o)
        else $error("calibration flags stayed after done");
    store_pulse_a: assert property (go && !locked_q && code == `SC_CNT_STORE |=> offset_store_o ##1 !offset_store_o)
        else $error("offset store pulse wrong");
    full_reset_gate_a: assert property (go && code == `SC_FULL_RESET |=> (full_reset_o == !locked_q) ##1 !full_reset_o)
        else $error("full reset pulse wrong for access state");
    alg_start_a: assert property (go && !locked_q && code == `SC_ALG_START |=> update_state_o[`UPD_ALG_BIT])
        else $error("algorithm start bit not set");
    alg_sticky_a: assert property (update_state_o[`UPD_ALG_BIT] |=> update_state_o[`UPD_ALG_BIT])
        else $error("algorithm start bit cleared");
    wake_clear_a: assert property (deep_sleep_o && (wr_i || rd_i) |=> !deep_sleep_o)
        else $error("deep sleep kept after access");
    stretch_wire_a: assert property (stretch_o |-> !link_sel_i)
        else $error("stretch on single-wire link");
    stretch_len_a: assert property (st_cnt_q <= WAKE_COUNT + 32'd1)
        else $error("stretch too long");
    locked_cal_a: assert property (go && locked_q && code == `SC_BOARD_CAL |=> !$rose(board_cal_o))
        else $error("locked board calibration ran");
    cover property (go && code == `SC_LOCK);
    cover property ($rose(stretch_o));
    cover property (full_reset_o);
    cover property ($rose(drop_o));
endmodule // gauge_ctl_sva
bind gauge_control_subcommand_unit gauge_ctl_sva #(.WAKE_COUNT(WAKE_COUNT)) gauge_ctl_sva_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .stretch_o(stretch_o), .drop_o(drop_o), .link_sel_i(link_sel_i), .cal_done_i(cal_done_i),
    .board_cal_o(board_cal_o), .cnt_cal_o(cnt_cal_o), .offset_store_o(offset_store_o),
    .full_reset_o(full_reset_o), .deep_sleep_o(deep_sleep_o), .update_state_o(update_state_o));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the control subcommand unit
`timescale 1ns/1ns
`default_nettype none
`include "gauge_ctl_consts.vh"
module tb_top;
    localparam logic [15:0] TYPE_V = 16'h5a01; // Arbitrary identity value
    localparam logic [15:0] FW_V = 16'h0203, HW_V = 16'h0004, CHEM_V = 16'h0310, FL_V = 16'h0022;
    logic        clock_i, rst_n_i, link_sel_i, sleep_i, volt_ok_i, rud_i, pm_i, cal_done_i;
    logic        wr, rd, stretch, drop, board_cal, cnt_cal, store, full_reset, deep_sleep;
    logic [7:0]  addr, wdata, rdata, upd, rb;
    logic [3:0]  idx;
    logic [15:0] current_i, offset_i, chem_word, chem_ref_i;
    int          error_cnt = 0, num_checks = 0, resets = 0, sum;
    logic        locked = 0, cal = 0, bca = 0, cca = 0, ds = 0, alg = 0, checksum_valid_flag = 0; // Reference state
    logic [15:0] last_q[$];           // Subcommands the reference has run
    logic [31:0] seed = 32'h9cf4;     // Fixed seed keeps runs repeatable
    host_model host_model_i (.clock_i(clock_i), .idx_i(idx), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata), .word_o(chem_word));
    gauge_control_subcommand_unit #(.TYPE_CODE(TYPE_V), .FW_REV(FW_V), .HW_REV(HW_V), .CHEM_CODE(CHEM_V),
        .FLASH_REV(FL_V), .WAKE_COUNT(32'd10)) gauge_control_subcommand_unit_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata),
        .rdata_o(rdata), .stretch_o(stretch), .drop_o(drop), .link_sel_i(link_sel_i), .sleep_i(sleep_i),
        .volt_ok_i(volt_ok_i), .res_upd_dis_i(rud_i), .power_mode_i(pm_i), .current_i(current_i),
        .offset_i(offset_i), .chem_word_i(chem_word), .chem_ref_i(chem_ref_i), .cal_done_i(cal_done_i),
        .chem_idx_o(idx), .board_cal_o(board_cal), .cnt_cal_o(cnt_cal), .offset_store_o(store),
        .full_reset_o(full_reset), .deep_sleep_o(deep_sleep), .update_state_o(upd));
    // Free-running bench clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // Shift-register random source
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Subcommands that stay open while locked
    function automatic logic open_locked(input logic [15:0] c);
        return c inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h000c, 16'h0017, 16'h0018};
    endfunction
    // Issue a subcommand and advance the reference state
    task automatic run(input logic [15:0] c);
        host_model_i.cmd(c);
        if (locked && !open_locked(c)) return;
        case (c)
            `SC_BOARD_CAL: bca = 1'b1;
            `SC_CNT_CAL: cca = 1'b1;
            `SC_DEEP_SLEEP: ds = 1'b1;
            `SC_LOCK: locked = 1'b1;
            `SC_ALG_START: alg = 1'b1;
            `SC_CAL_TOGGLE: cal = !cal;
            `SC_CAL_EXIT: cal = 1'b0;
            `SC_CAL_ENTER: cal = 1'b1;
            `SC_FULL_RESET: resets++;
            default: ;
        endcase
        if (c < `LAST_SUB_LIMIT) last_q.push_back(c);
    endtask
    task automatic read_chk(input logic [15:0] exp);
        logic [15:0] w;
        host_model_i.read_word(w);
        check(w, exp);
    endtask
    task automatic query(input logic [15:0] c, input logic [15:0] exp);
        run(c);
        read_chk(exp);
    endtask
    // Status word from the reference
    task automatic check_st();
        logic [15:0] w;
        run(`SC_STATUS);
        host_model_i.read_word(w);
        check(w, {1'b0, locked, locked, cal, cca, bca, checksum_valid_flag, 3'h0, ds, sleep_i, pm_i, rud_i, volt_ok_i & alg, alg});
    endtask
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        {link_sel_i, sleep_i, volt_ok_i, rud_i, pm_i, cal_done_i} = 6'b001000;
        {current_i, offset_i, chem_ref_i} = 48'h0;
        repeat (8) @(negedge clock_i);
        {rst_n_i, rud_i, current_i, offset_i} = {1'b1, 1'(rnd()), 16'(rnd()), 16'(rnd())};
        check_st();
        query(`SC_TYPE, TYPE_V);
        query(`SC_FW_REV, FW_V);
        query(`SC_HW_REV, HW_V);
        query(`SC_CHEM_CODE, CHEM_V);
        query(`SC_FLASH_REV, FL_V);
        query(`SC_CURRENT, current_i);
        run(`SC_ALG_START);
        check(16'(upd[`UPD_ALG_BIT]), 16'h0001);
        query(`SC_LAST_SUB, last_q[$]);
        check_st();
        {volt_ok_i, pm_i} = 2'b01; // Constant-power mode from here on
        check_st();
        volt_ok_i = 1'b1;
        run(`SC_CAL_ENTER);
        check_st();
        query(`SC_CAL_OFFSET, offset_i);
        run(`SC_CAL_TOGGLE);
        check_st();
        run(`SC_CAL_TOGGLE);
        run(`SC_CAL_EXIT);
        check_st();
        run(`SC_BOARD_CAL);
        run(`SC_CNT_CAL);
        check_st();
        run(`SC_CNT_STORE);
        check(16'(store), 16'h0001);
        cal_done_i = 1'b1;
        @(negedge clock_i);
        {cal_done_i, bca, cca} = 3'b000;
        check_st();
        run(`SC_FULL_RESET);
        check(16'(full_reset), 16'h0001);
        query(`SC_RESET_COUNT, 16'(resets));
        sum = 0;
        for (int i = 0; i < `CHEM_WORDS; i++) begin
            host_model_i.table_q[i] = 16'(rnd());
            sum += host_model_i.table_q[i];
        end
        // Matching reference first, then one bit off
        for (int k = 0; k < 2; k++) begin
            chem_ref_i = (16'(sum) & 16'h7fff) ^ 16'(k);
            run(`SC_CHEM_SUM);
            repeat (20) @(negedge clock_i);
            read_chk(16'(sum) & 16'h7fff | (k ? 16'h8000 : 16'h0000));
        end
        checksum_valid_flag = 1'b1;
        // Two-wire wake stretches the clock, single-wire wake drops the message
        for (int m = 0; m < 2; m++) begin
            link_sel_i = 1'(m);
            run(`SC_DEEP_SLEEP);
            check_st();
            sleep_i = 1'b1;
            for (int k = 0; k < 20 && !deep_sleep; k++) @(negedge clock_i);
            check(16'(deep_sleep), 16'h0001);
            host_model_i.get(8'h00, rb);
            check({deep_sleep, m ? drop : stretch}, 16'h0001);
            for (int k = 0; k < 50 && (m ? drop : stretch); k++) @(negedge clock_i);
            check(16'(m ? drop : stretch), 16'h0000);
            {sleep_i, ds} = 2'b00;
            check_st();
        end
        run(`SC_LOCK);
        check_st();
        query(`SC_CURRENT, current_i);
        query(`SC_RESET_COUNT, current_i);
        run(`SC_FULL_RESET);
        check(16'(full_reset), 16'h0000);
        run(`SC_BOARD_CAL);
        check_st();
        query(`SC_TYPE, TYPE_V);
        give_verdict();
    end
    // Watchdog sized well past the expected run
    initial begin
        #(40 * 6000);
        error_cnt++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
